// *** pwmt_pkg.sv ***
package pwmt_pkg;
    localparam int ADDR_W = 8;
    localparam int CNT_W  = 16;
    localparam int NCH    = 2;

    localparam logic [ADDR_W-1:0] OFS_CTRL_A = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_CTRL_B = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_COUNT  = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_CMP_A  = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_CMP_B  = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_CAPT   = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_FLAGS  = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_DIR    = 8'h1c;

    localparam int CA_COM_A_LSB = 6;
    localparam int CA_COM_B_LSB = 4;
    localparam int CA_MODE_LSB  = 0;
    localparam int CB_MODE_LSB  = 3;
    localparam int CB_CS_LSB    = 0;

    localparam int FLG_OVF  = 0;
    localparam int FLG_CMPA = 1;
    localparam int FLG_CAPT = 3;

    localparam logic [CNT_W-1:0] TOP_8   = 16'h00ff;
    localparam logic [CNT_W-1:0] TOP_9   = 16'h01ff;
    localparam logic [CNT_W-1:0] TOP_10  = 16'h03ff;
    localparam logic [CNT_W-1:0] TOP_MAX = 16'hffff;
    localparam logic [CNT_W-1:0] BOTTOM  = 16'h0000;

    localparam logic [3:0] MODE_PC8       = 4'h1;
    localparam logic [3:0] MODE_PC9       = 4'h2;
    localparam logic [3:0] MODE_PC10      = 4'h3;
    localparam logic [3:0] MODE_PFC_CAPT  = 4'h8;
    localparam logic [3:0] MODE_PFC_CMPA  = 4'h9;
    localparam logic [3:0] MODE_PC_CAPT   = 4'ha;
    localparam logic [3:0] MODE_PC_CMPA   = 4'hb;

    localparam logic [1:0] COM_OFF    = 2'h0;
    localparam logic [1:0] COM_TOGGLE = 2'h1;
    localparam logic [1:0] COM_NONINV = 2'h2;
    localparam logic [1:0] COM_INV    = 2'h3;

    localparam logic [2:0] CS_DIV1    = 3'h1;
    localparam logic [2:0] CS_DIV8    = 3'h2;
    localparam logic [2:0] CS_DIV64   = 3'h3;
    localparam logic [2:0] CS_DIV256  = 3'h4;
    localparam logic [2:0] CS_DIV1024 = 3'h5;
    localparam logic [9:0] PRE_M8     = 10'h007;
    localparam logic [9:0] PRE_M64    = 10'h03f;
    localparam logic [9:0] PRE_M256   = 10'h0ff;
    localparam logic [9:0] PRE_M1024  = 10'h3ff;

    typedef enum logic [1:0] {
        PWMT_UP   = 2'b01,
        PWMT_DOWN = 2'b10
    } pwmt_dir_t;

    typedef struct packed {
        logic [NCH-1:0][1:0] com;
        logic [3:0]          waveform_mode_code;
        logic [2:0]          cs;
    } pwmt_ctrl_t;

    typedef struct packed {
        pwmt_ctrl_t                    ctrl;
        logic [CNT_W-1:0]              count_value;
        pwmt_dir_t                     dir;
        logic [NCH-1:0][CNT_W-1:0]     buf_v;
        logic [NCH-1:0][CNT_W-1:0]     compare_value_reg;
        logic [CNT_W-1:0]              capture_value_reg;
        logic [3:0]                    flags;
        logic [NCH-1:0]                pin_direction_bit;
        logic [9:0]                    presc;
        logic [NCH-1:0]                out;
        logic [NCH-1:0]                oe;
        logic [31:0]                   prdata;
        logic                          pready;
        logic                          pslverr;
    } pwmt_state_t;
endpackage

// *** pwmt_timer.sv ***
`timescale 1ns/1ps
module pwmt_timer
    import pwmt_pkg::*;
(
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    output logic [NCH-1:0]         compare_output_pin,
    output logic [NCH-1:0]         compare_output_oe
);
    pwmt_state_t      s;
    pwmt_state_t      n;
    logic             tick;
    logic             run;
    logic             pc;
    logic             fixed;
    logic             a_top;
    logic             c_top;
    logic [CNT_W-1:0] top;
    logic [CNT_W-1:0] wmask;
    logic [NCH-1:0]   match;
    logic [3:0]       fset;
    logic [3:0]       fclr;
    logic [31:0]      rdata;
    logic             hit;
    logic             wr;
    logic             lvl;
    logic             inv;

    always_comb begin
        n     = s;
        fset  = 4'h0;
        fclr  = 4'h0;
        match = '0;
        lvl   = 1'b0;
        inv   = 1'b0;
        n.presc = s.presc + 10'h001;
        // The divider free-runs so each ratio gives one enable every N input clocks.
        case (s.ctrl.cs)
            CS_DIV1:    tick = 1'b1;
            CS_DIV8:    tick = (s.presc & PRE_M8) == PRE_M8;
            CS_DIV64:   tick = (s.presc & PRE_M64) == PRE_M64;
            CS_DIV256:  tick = (s.presc & PRE_M256) == PRE_M256;
            CS_DIV1024: tick = (s.presc & PRE_M1024) == PRE_M1024;
            default:    tick = 1'b0;
        endcase
        run   = 1'b1;
        pc    = 1'b1;
        fixed = 1'b0;
        a_top = 1'b0;
        c_top = 1'b0;
        case (s.ctrl.waveform_mode_code)
            MODE_PC8: begin
                top   = TOP_8;
                fixed = 1'b1;
            end
            MODE_PC9: begin
                top   = TOP_9;
                fixed = 1'b1;
            end
            MODE_PC10: begin
                top   = TOP_10;
                fixed = 1'b1;
            end
            MODE_PC_CAPT: begin
                top   = s.capture_value_reg;
                c_top = 1'b1;
            end
            MODE_PC_CMPA: begin
                top   = s.compare_value_reg[0];
                a_top = 1'b1;
            end
            MODE_PFC_CAPT: begin
                top   = s.capture_value_reg;
                c_top = 1'b1;
                pc    = 1'b0;
            end
            MODE_PFC_CMPA: begin
                top   = s.compare_value_reg[0];
                a_top = 1'b1;
                pc    = 1'b0;
            end
            default: begin
                // Modes outside the dual-slope set leave the counter frozen.
                top = TOP_MAX;
                run = 1'b0;
                pc  = 1'b0;
            end
        endcase
        wmask = fixed ? top : TOP_MAX;

        if (tick && run) begin
            for (int ch = 0; ch < NCH; ch++) begin
                match[ch] = s.count_value == s.compare_value_reg[ch];
                fset[FLG_CMPA + ch] = match[ch];
            end
            case (s.dir)
                PWMT_UP: begin
                    // Compare against at-or-above so a TOP lowered under the count still turns.
                    if (s.count_value >= top) begin
                        n.dir         = PWMT_DOWN;
                        n.count_value = s.count_value - 16'h0001;
                        fset[FLG_CAPT] = c_top;
                        if (pc) begin
                            n.compare_value_reg = s.buf_v;
                        end
                    end else begin
                        n.count_value = s.count_value + 16'h0001;
                    end
                end
                PWMT_DOWN: begin
                    if (s.count_value == BOTTOM) begin
                        n.dir          = PWMT_UP;
                        n.count_value  = s.count_value + 16'h0001;
                        fset[FLG_OVF]  = 1'b1;
                        if (!pc) begin
                            n.compare_value_reg = s.buf_v;
                        end
                    end else begin
                        n.count_value = s.count_value - 16'h0001;
                    end
                end
                default: n.dir = PWMT_UP;
            endcase
            for (int ch = 0; ch < NCH; ch++) begin
                inv = s.ctrl.com[ch] == COM_INV;
                if (s.ctrl.com[ch] == COM_NONINV || inv) begin
                    if (s.compare_value_reg[ch] == top) begin
                        n.out[ch] = ~inv;
                    end else if (s.compare_value_reg[ch] == BOTTOM) begin
                        n.out[ch] = inv;
                    end else if (match[ch]) begin
                        lvl       = s.dir == PWMT_DOWN;
                        n.out[ch] = lvl ^ inv;
                    end
                end else if (s.ctrl.com[ch] == COM_TOGGLE && ch == 0 && a_top && match[ch]) begin
                    n.out[ch] = ~s.out[ch];
                end
            end
        end

        for (int ch = 0; ch < NCH; ch++) begin
            // Toggle mode drives only channel A and only with compare A as TOP.
            n.oe[ch] = s.pin_direction_bit[ch] && s.ctrl.com[ch] != COM_OFF
                       && (s.ctrl.com[ch] != COM_TOGGLE || (ch == 0 && a_top));
        end

        hit   = 1'b1;
        rdata = 32'h0000_0000;
        case (paddr)
            OFS_CTRL_A: begin
                rdata[CA_COM_A_LSB +: 2] = s.ctrl.com[0];
                rdata[CA_COM_B_LSB +: 2] = s.ctrl.com[1];
                rdata[CA_MODE_LSB +: 2]  = s.ctrl.waveform_mode_code[1:0];
            end
            OFS_CTRL_B: begin
                rdata[CB_MODE_LSB +: 2] = s.ctrl.waveform_mode_code[3:2];
                rdata[CB_CS_LSB +: 3]   = s.ctrl.cs;
            end
            OFS_COUNT: rdata[CNT_W-1:0] = s.count_value;
            OFS_CMP_A: rdata[CNT_W-1:0] = s.buf_v[0];
            OFS_CMP_B: rdata[CNT_W-1:0] = s.buf_v[1];
            OFS_CAPT:  rdata[CNT_W-1:0] = s.capture_value_reg;
            OFS_FLAGS: rdata[3:0] = s.flags;
            OFS_DIR:   rdata[NCH-1:0] = s.pin_direction_bit;
            default:   hit = 1'b0;
        endcase

        // One wait state: data and ready are registered in the first access cycle.
        n.pready  = psel && penable && !s.pready;
        n.prdata  = (psel && penable && !s.pready && !pwrite) ? rdata : 32'h0000_0000;
        n.pslverr = psel && penable && !s.pready && !hit;
        wr = psel && penable && pwrite && s.pready && hit;
        if (wr) begin
            case (paddr)
                OFS_CTRL_A: begin
                    n.ctrl.com[0] = pwdata[CA_COM_A_LSB +: 2];
                    n.ctrl.com[1] = pwdata[CA_COM_B_LSB +: 2];
                    n.ctrl.waveform_mode_code[1:0] = pwdata[CA_MODE_LSB +: 2];
                end
                OFS_CTRL_B: begin
                    n.ctrl.waveform_mode_code[3:2] = pwdata[CB_MODE_LSB +: 2];
                    n.ctrl.cs = pwdata[CB_CS_LSB +: 3];
                end
                OFS_COUNT: n.count_value = pwdata[CNT_W-1:0];
                OFS_CMP_A: begin
                    n.buf_v[0] = pwdata[CNT_W-1:0] & wmask;
                    if (!run) begin
                        n.compare_value_reg[0] = pwdata[CNT_W-1:0] & wmask;
                    end
                end
                OFS_CMP_B: begin
                    n.buf_v[1] = pwdata[CNT_W-1:0] & wmask;
                    if (!run) begin
                        n.compare_value_reg[1] = pwdata[CNT_W-1:0] & wmask;
                    end
                end
                OFS_CAPT:  n.capture_value_reg = pwdata[CNT_W-1:0];
                OFS_FLAGS: fclr = pwdata[3:0];
                OFS_DIR:   n.pin_direction_bit = pwdata[NCH-1:0];
                default:   n.flags = s.flags;
            endcase
        end
        // A hardware set in the same cycle as a software clear survives.
        n.flags = (s.flags & ~fclr) | fset;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s     <= '0;
            s.dir <= PWMT_UP;
        end else begin
            s <= n;
        end
    end

    assign prdata             = s.prdata;
    assign pready             = s.pready;
    assign pslverr            = s.pslverr;
    assign compare_output_pin = s.out;
    assign compare_output_oe  = s.oe;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    AST_FIXED_TOP: assert property (s.ctrl.waveform_mode_code == MODE_PC9 |-> top == TOP_9)
        else $error("fixed top wrong");
    AST_PFC_TOP: assert property (s.ctrl.waveform_mode_code == MODE_PFC_CAPT |-> top == s.capture_value_reg)
        else $error("pfc top source wrong");
    AST_COUNT_UP: assert property (tick && run && s.dir == PWMT_UP && s.count_value < top && !wr
        |=> s.count_value == $past(s.count_value) + 16'h0001)
        else $error("counter did not step up");
    AST_TOP_TURN: assert property (tick && run && s.dir == PWMT_UP && s.count_value == top && !wr
        |=> s.dir == PWMT_DOWN && s.count_value == $past(s.count_value) - 16'h0001)
        else $error("turn at top wrong");
    AST_OVF_BOTTOM: assert property (tick && run && s.dir == PWMT_DOWN && s.count_value == BOTTOM
        |=> s.flags[FLG_OVF])
        else $error("overflow flag not set at bottom");
    AST_PC_LOAD: assert property (tick && pc && s.dir == PWMT_UP && s.count_value == top
        |=> s.compare_value_reg == $past(s.buf_v))
        else $error("compare not loaded at top");
    AST_PFC_LOAD: assert property (tick && run && !pc && s.dir == PWMT_UP && s.count_value == top
        |=> $stable(s.compare_value_reg))
        else $error("pfc compare loaded at top");
    AST_MATCH_FLAG: assert property (tick && run && s.count_value == s.compare_value_reg[1]
        |=> s.flags[FLG_CMPA + 1])
        else $error("match flag missing");
    AST_CLEAR_UP: assert property (tick && run && s.dir == PWMT_UP && s.ctrl.com[1] == COM_NONINV
        && s.count_value == s.compare_value_reg[1] && s.count_value != top && s.count_value != BOTTOM
        |=> !s.out[1])
        else $error("output not cleared on up match");
    AST_LOW_AT_BOTTOM: assert property (tick && run && s.ctrl.com[1] == COM_NONINV
        && s.compare_value_reg[1] == BOTTOM && top != BOTTOM ##1 !$changed(s.ctrl) |-> !s.out[1])
        else $error("zero duty output not low");
    AST_MASK: assert property (wr && fixed && paddr == OFS_CMP_B |=> (s.buf_v[1] & ~$past(top)) == BOTTOM)
        else $error("compare write not masked");
    AST_PC8_TOP: assert property (s.ctrl.waveform_mode_code == MODE_PC8 |-> top == TOP_8)
        else $error("8-bit top wrong");
    AST_PFC_CMPA_TOP: assert property (s.ctrl.waveform_mode_code == MODE_PFC_CMPA
        |-> top == s.compare_value_reg[0])
        else $error("pfc compare a top wrong");
    AST_COUNT_DOWN: assert property (tick && run && s.dir == PWMT_DOWN && s.count_value != BOTTOM && !wr
        |=> s.count_value == $past(s.count_value) - 16'h0001)
        else $error("counter did not step down");
    AST_BOTTOM_TURN: assert property (tick && run && s.dir == PWMT_DOWN && s.count_value == BOTTOM && !wr
        |=> s.dir == PWMT_UP && s.count_value == $past(s.count_value) + 16'h0001)
        else $error("turn at bottom wrong");
    // A count that moved between ticks would stretch the period away from the prescaled rate.
    AST_HOLD_NO_TICK: assert property (!(tick && run) && !wr |=> $stable(s.count_value))
        else $error("counter moved without a tick");
    AST_PC_KEEP_BOTTOM: assert property (tick && pc && s.dir == PWMT_DOWN && s.count_value == BOTTOM
        |=> $stable(s.compare_value_reg))
        else $error("phase correct compare loaded at bottom");
    AST_PFC_BOTTOM: assert property (tick && run && !pc && s.dir == PWMT_DOWN && s.count_value == BOTTOM
        |=> s.flags[FLG_OVF] && s.compare_value_reg == $past(s.buf_v))
        else $error("pfc bottom update wrong");
    AST_CMPA_AT_TOP: assert property (tick && run && a_top && s.dir == PWMT_UP && s.count_value == top
        |=> s.flags[FLG_CMPA])
        else $error("compare a flag missing at top");
    AST_CAPT_AT_TOP: assert property (tick && run && c_top && s.dir == PWMT_UP && s.count_value == top
        |=> s.flags[FLG_CAPT])
        else $error("capture flag missing at top");
    AST_SET_DOWN: assert property (tick && run && s.dir == PWMT_DOWN && s.ctrl.com[0] == COM_NONINV
        && s.count_value == s.compare_value_reg[0] && s.count_value != top && s.count_value != BOTTOM
        |=> s.out[0])
        else $error("output not set on down match");
    AST_INV_UP: assert property (tick && run && s.dir == PWMT_UP && s.ctrl.com[1] == COM_INV
        && s.count_value == s.compare_value_reg[1] && s.count_value != top && s.count_value != BOTTOM
        |=> s.out[1])
        else $error("inverted output not set on up match");
    AST_HIGH_AT_TOP: assert property (tick && run && s.ctrl.com[0] == COM_NONINV
        && s.compare_value_reg[0] == top |=> s.out[0])
        else $error("full duty output not high");
    AST_INV_LOW_AT_TOP: assert property (tick && run && s.ctrl.com[0] == COM_INV
        && s.compare_value_reg[0] == top |=> !s.out[0])
        else $error("inverted full duty output not low");
    AST_TOGGLE: assert property (tick && run && a_top && s.ctrl.com[0] == COM_TOGGLE
        && s.count_value == s.compare_value_reg[0] |=> s.out[0] != $past(s.out[0]))
        else $error("channel a did not toggle");
    AST_MASK_A: assert property (wr && fixed && paddr == OFS_CMP_A
        |=> (s.buf_v[0] & ~$past(top)) == BOTTOM)
        else $error("compare a write not masked");
    AST_BUF_ONLY: assert property (wr && run && !tick && paddr == OFS_CMP_A
        |=> $stable(s.compare_value_reg[0]))
        else $error("active compare written directly");
    AST_MODE_HIGH: assert property (wr && paddr == OFS_CTRL_B
        |=> s.ctrl.waveform_mode_code[3:2] == $past(pwdata[CB_MODE_LSB +: 2]))
        else $error("mode code high bits wrong");
    AST_MODE_LOW: assert property (wr && paddr == OFS_CTRL_A
        |=> s.ctrl.waveform_mode_code[1:0] == $past(pwdata[CA_MODE_LSB +: 2]))
        else $error("mode code low bits wrong");
endmodule

// *** pwmt_load.sv ***
`timescale 1ns/1ps
// Load on one channel output; a pull-down holds the node low while the pin is undriven.
module pwmt_load (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        pin,
    input  wire logic        oe,
    input  wire logic        clr,
    output logic [31:0]      high_cnt,
    output logic [31:0]      rise_cnt
);
    logic node;
    logic prev;
    assign node = oe & pin;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            high_cnt <= 32'h0;
            rise_cnt <= 32'h0;
            prev     <= 1'b0;
        end else if (clr) begin
            high_cnt <= 32'h0;
            rise_cnt <= 32'h0;
            prev     <= node;
        end else begin
            high_cnt <= high_cnt + {31'h0, node};
            rise_cnt <= rise_cnt + {31'h0, node & ~prev};
            prev     <= node;
        end
    end
endmodule

// *** testbench.sv ***
`timescale 1ns/1ps
module testbench
    import pwmt_pkg::*;
;
    typedef struct {int mode; int top; int ca; int cb; int coma; int comb; int cs; int dv; int dir;} pwmt_scn_t;
    localparam int LIMIT = 80000;
    logic              pclk    = 1'b0;
    logic              presetn = 1'b0;
    logic              psel    = 1'b0;
    logic              penable = 1'b0;
    logic              pwrite  = 1'b0;
    logic [ADDR_W-1:0] paddr   = 8'h00;
    logic [31:0]       pwdata  = 32'h0;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
    logic [NCH-1:0]    pin;
    logic [NCH-1:0]    oe;
    logic              clr     = 1'b0;
    wire [1:0][31:0]   hcnt;
    wire [1:0][31:0]   rcnt;
    logic [15:0]       seed    = 16'h004e;
    int                n_fail  = 0;
    int                comparisons = 0;
    int                cycles  = 0;
    pwmt_scn_t         scns[$];

    pwmt_timer uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .compare_output_pin(pin), .compare_output_oe(oe));
    pwmt_load load_a (.pclk(pclk), .presetn(presetn), .pin(pin[0]), .oe(oe[0]), .clr(clr),
        .high_cnt(hcnt[0]), .rise_cnt(rcnt[0]));
    pwmt_load load_b (.pclk(pclk), .presetn(presetn), .pin(pin[1]), .oe(oe[1]), .clr(clr),
        .high_cnt(hcnt[1]), .rise_cnt(rcnt[1]));

    always #12.5 pclk = ~pclk;

    task automatic end_of_test();
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    always @(posedge pclk) begin
        cycles++;
        if (cycles == LIMIT) begin
            n_fail++;
            end_of_test();
        end
    end

    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch register at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_wave(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch waveform at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Entered at a rising edge; leaves one idle cycle so psel is never driven twice in a step.
    task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Only the bench timeout ends a wait for ready.
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        chk_reg(r, exp);
    endtask

    function automatic logic [15:0] lfsr(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction

    function automatic int rnd(input int top);
        seed = lfsr(seed);
        return int'(seed) % (top + 1);
    endfunction

    // High time is 2*C ticks (2*(TOP-C) inverted, TOP on average when toggling) of each 2*TOP-tick period; the window spans two periods.
    function automatic int exp_high(input int com, input int c, input int top, input int dv, input bit d);
        if (!d) return 0;
        if (com == 1) return 2 * dv * top;
        if (com == 2) return 4 * dv * c;
        return 4 * dv * (top - c);
    endfunction

    function automatic int exp_rise(input int com, input int c, input int top, input bit d);
        if (!d) return 0;
        if (com == 1) return 1;
        return (c == 0 || c == top) ? 0 : 2;
    endfunction

    task automatic run(input pwmt_scn_t s);
        logic [31:0] hi_b;
        int p;
        int ch;
        hi_b = {27'h0, s.mode[3:2], 3'h0};
        p = 2 * s.dv * s.top;
        // Compares go in while the counter is frozen, so no stale active value can act as TOP.
        wr(OFS_CTRL_B, 32'h0);
        wr(OFS_CTRL_A, 32'h0);
        wr(OFS_COUNT, 32'h0);
        wr(OFS_CMP_A, (s.mode == 9) ? s.ca + 8 : s.ca);
        wr(OFS_CMP_B, s.cb);
        if (s.mode == 8 || s.mode == 10) wr(OFS_CAPT, s.top);
        wr(OFS_CTRL_B, hi_b);
        wr(OFS_CTRL_A, {24'h0, s.coma[1:0], s.comb[1:0], 2'h0, s.mode[1:0]});
        if (s.mode < 4) begin
            wr(OFS_CMP_A, 32'h0000ffff);
            wr(OFS_CMP_B, 32'h0000ffff);
            rd_chk(OFS_CMP_A, s.top);
            rd_chk(OFS_CMP_B, s.top);
            wr(OFS_CMP_A, s.ca);
            wr(OFS_CMP_B, s.cb);
        end
        wr(OFS_DIR, s.dir);
        wr(OFS_CTRL_B, hi_b | s.cs);
        // A new TOP written to the double-buffered compare A while running takes hold at BOTTOM.
        if (s.mode == 9) wr(OFS_CMP_A, s.ca);
        repeat (2 * p) @(posedge pclk);
        clr <= 1'b1;
        @(posedge pclk);
        clr <= 1'b0;
        repeat (2 * p + 1) @(posedge pclk);
        for (ch = 0; ch < 2; ch++) begin
            chk_wave(hcnt[ch], exp_high(ch ? s.comb : s.coma, ch ? s.cb : s.ca, s.top, s.dv, s.dir[ch]));
            chk_wave(rcnt[ch], exp_rise(ch ? s.comb : s.coma, ch ? s.cb : s.ca, s.top, s.dir[ch]));
        end
        chk_reg({30'h0, oe}, {30'h0, s.dir[1] && s.comb != 0, s.dir[0] && s.coma != 0});
        wr(OFS_CTRL_B, hi_b);
        rd_chk(OFS_FLAGS, (s.mode == 8 || s.mode == 10) ? 32'hf : 32'h7);
        wr(OFS_FLAGS, 32'hf);
        rd_chk(OFS_FLAGS, 32'h0);
    endtask

    initial begin
        logic [31:0] r;
        logic e;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd_chk(OFS_CTRL_A, 32'h0);
        apb(1'b0, 8'h20, 32'h0, r, e);
        chk_reg(r, 32'h0);
        chk_reg({31'h0, e}, 32'h1);
        // Register-defined TOP stays at or above 3 and at or above every compare value.
        scns.push_back('{1, 255, rnd(255), rnd(255), 2, 3, 1, 1, 3});
        scns.push_back('{2, 511, 511, 0, 2, 2, 1, 1, 3});
        scns.push_back('{3, 1023, 1023, 0, 3, 3, 1, 1, 3});
        scns.push_back('{10, 20, rnd(20), rnd(20), 2, 3, 2, 8, 3});
        scns.push_back('{11, 30, 30, rnd(30), 1, 2, 1, 1, 1});
        scns.push_back('{8, 12, rnd(12), rnd(12), 3, 2, 3, 64, 3});
        scns.push_back('{9, 25, 25, rnd(25), 1, 3, 1, 1, 3});
        scns.push_back('{8, 3, rnd(3), rnd(3), 2, 3, 5, 1024, 3});
        scns.push_back('{10, 3, rnd(3), rnd(3), 3, 2, 4, 256, 2});
        foreach (scns[i]) run(scns[i]);
        end_of_test();
    end
endmodule
